// [fifo_prog_flags.v]
// synchronous 9-bit fifo with empty, full and programmable almost flags
`timescale 1ns/100ps
`include "fifo_prog_regs.vh"

module fifo_prog_flags #(
    parameter ADDR_W = `FIFO_ADDR_W_DEF
) (
    input  wire                    core_clk,
    input  wire                    rstn,
    input  wire [`FIFO_DATA_W-1:0] write_data_in,
    input  wire                    primary_write_enable_n,
    input  wire                    second_write_enable_or_load,
    input  wire                    first_read_enable_n,
    input  wire                    second_read_enable_n,
    input  wire                    output_enable_n,
    output reg  [`FIFO_DATA_W-1:0] read_data_out,
    output reg                     read_data_oe,
    output reg                     empty_flag_n,
    output reg                     full_flag_n,
    output reg                     almost_empty_flag_n,
    output reg                     almost_full_flag_n
);

    localparam PTR_W = ADDR_W + 1;
    localparam CNT_X = 17;
    localparam [CNT_X-1:0] DEPTH_X = 17'h00001 << ADDR_W;

    // ------------------------------------------------------------
    // mode captured at reset
    // ------------------------------------------------------------

    // high: second write enable; low: offset load strobe
    reg mode_two_enables_reg;

    always @(posedge core_clk) begin
        if (!rstn) begin
            // reset is synchronous, so the pin level is a legal capture
            mode_two_enables_reg <= second_write_enable_or_load;
        end
    end

    wire offset_load_strobe_n = mode_two_enables_reg | second_write_enable_or_load;
    wire load_mode            = ~mode_two_enables_reg;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------

    wire read_pair_low = ~first_read_enable_n & ~second_read_enable_n;

    // buffer write request before the full check
    reg write_req;
    always @* begin
        if (load_mode) begin
            write_req = ~primary_write_enable_n & offset_load_strobe_n;
        end else begin
            write_req = ~primary_write_enable_n & second_write_enable_or_load;
        end
    end

    wire offset_write = load_mode & ~offset_load_strobe_n & ~primary_write_enable_n;
    wire offset_read  = load_mode & ~offset_load_strobe_n & read_pair_low;

    // in load mode with the strobe low the read enables address offsets
    wire read_req = read_pair_low & offset_load_strobe_n;

    // the registered flags gate acceptance, so a blocked request has no effect
    wire write_take = write_req & full_flag_n;
    wire read_take  = read_req & empty_flag_n;

    // ------------------------------------------------------------
    // pointers and storage
    // ------------------------------------------------------------

    reg  [PTR_W-1:0] write_ptr_reg;
    reg  [PTR_W-1:0] read_ptr_reg;
    wire [PTR_W-1:0] write_ptr_next = write_take ? write_ptr_reg + 1'b1 : write_ptr_reg;
    wire [PTR_W-1:0] read_ptr_next  = read_take ? read_ptr_reg + 1'b1 : read_ptr_reg;
    wire [PTR_W-1:0] write_ptr_seen;
    wire [PTR_W-1:0] read_ptr_seen;
    wire [`FIFO_DATA_W-1:0] stored_word;

    always @(posedge core_clk) begin
        if (!rstn) begin
            write_ptr_reg <= {PTR_W{1'b0}};
            read_ptr_reg  <= {PTR_W{1'b0}};
        end else begin
            write_ptr_reg <= write_ptr_next;
            read_ptr_reg  <= read_ptr_next;
        end
    end

    fifo_storage #(
        .ADDR_W (ADDR_W),
        .DATA_W (`FIFO_DATA_W)
    ) storage_u (
        .core_clk     (core_clk),
        .write_strobe (write_take),
        .write_addr   (write_ptr_reg[ADDR_W-1:0]),
        .write_word   (write_data_in),
        .read_addr    (read_ptr_reg[ADDR_W-1:0]),
        .read_word    (stored_word)
    );

    // write pointer as seen by the read-side flag logic
    pointer_gray_cross #(
        .PTR_W (PTR_W)
    ) write_cross_u (
        .core_clk (core_clk),
        .rstn     (rstn),
        .bin_in   (write_ptr_reg),
        .bin_out  (write_ptr_seen)
    );

    // read pointer as seen by the write-side flag logic
    pointer_gray_cross #(
        .PTR_W (PTR_W)
    ) read_cross_u (
        .core_clk (core_clk),
        .rstn     (rstn),
        .bin_in   (read_ptr_reg),
        .bin_out  (read_ptr_seen)
    );

    // ------------------------------------------------------------
    // offset registers
    // ------------------------------------------------------------

    reg [1:0]           seq_pos_reg;
    reg [`OFFSET_W-1:0] offset_reg [0:3];

    function [`OFFSET_W-1:0] offset_reset;
        input [1:0] pos;
        begin
            case (pos)
                `SEQ_EMPTY_LOW: offset_reset = `OFFSET_LOW_RST;
                `SEQ_FULL_LOW:  offset_reset = `OFFSET_LOW_RST;
                default:        offset_reset = `OFFSET_HIGH_RST;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : offset_bank
            localparam [1:0] POS = g;
            always @(posedge core_clk) begin
                if (!rstn) begin
                    offset_reg[g] <= offset_reset(POS);
                end else if (offset_write && seq_pos_reg == POS) begin
                    offset_reg[g] <= write_data_in[`OFFSET_W-1:0];
                end
            end
        end
    endgenerate

    // one position shared by loads and readback; raising the strobe keeps it
    always @(posedge core_clk) begin
        if (!rstn) begin
            seq_pos_reg <= `SEQ_EMPTY_LOW;
        end else if (offset_write || offset_read) begin
            seq_pos_reg <= seq_pos_reg + 2'h1;
        end
    end

    wire [15:0] empty_offset = {offset_reg[`SEQ_EMPTY_HIGH], offset_reg[`SEQ_EMPTY_LOW]};
    wire [15:0] full_offset  = {offset_reg[`SEQ_FULL_HIGH], offset_reg[`SEQ_FULL_LOW]};

    // ------------------------------------------------------------
    // word counts on each side
    // ------------------------------------------------------------

    // read side counts against the delayed write pointer: it only under-reports
    wire [PTR_W-1:0] read_side_count  = write_ptr_seen - read_ptr_next;
    // write side counts against the delayed read pointer: it only over-reports
    wire [PTR_W-1:0] write_side_count = write_ptr_next - read_ptr_seen;

    wire [CNT_X-1:0] read_count_x  = {{(CNT_X-PTR_W){1'b0}}, read_side_count};
    wire [CNT_X-1:0] write_count_x = {{(CNT_X-PTR_W){1'b0}}, write_side_count};

    wire empty_now        = (read_count_x == {CNT_X{1'b0}});
    wire almost_empty_now = (read_count_x <= {1'b0, empty_offset});
    wire full_now         = (write_count_x == DEPTH_X);
    wire almost_full_now  = ((write_count_x + {1'b0, full_offset}) >= DEPTH_X);

    // ------------------------------------------------------------
    // flags, one flip-flop each
    // ------------------------------------------------------------

    // all flags share the single clock; each is a register, so it holds a cycle
    always @(posedge core_clk) begin
        if (!rstn) begin
            empty_flag_n        <= 1'b0;
            almost_empty_flag_n <= 1'b0;
            full_flag_n         <= 1'b1;
            almost_full_flag_n  <= 1'b1;
        end else begin
            empty_flag_n        <= ~empty_now;
            almost_empty_flag_n <= ~almost_empty_now;
            full_flag_n         <= ~full_now;
            almost_full_flag_n  <= ~almost_full_now;
        end
    end

    // ------------------------------------------------------------
    // output register and drive enable
    // ------------------------------------------------------------

    reg [`FIFO_DATA_W-1:0] read_data_next;
    always @* begin
        read_data_next = read_data_out;
        if (offset_read) begin
            read_data_next = {1'b0, offset_reg[seq_pos_reg]};
        end else if (read_take) begin
            read_data_next = stored_word;
        end
        // otherwise the last word read stays on the outputs
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            read_data_out <= `READ_DATA_RST;
            read_data_oe  <= 1'b0;
        end else begin
            read_data_out <= read_data_next;
            read_data_oe  <= ~output_enable_n;
        end
    end

endmodule // fifo_prog_flags

// [fifo_prog_flags_props.sv]
// assertions on the ports of the programmable-flag fifo
`timescale 1ns/100ps
module fifo_prog_flags_props #(
    parameter ADDR_W = 6
) (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [8:0] write_data_in,
    input wire logic       primary_write_enable_n,
    input wire logic       second_write_enable_or_load,
    input wire logic       first_read_enable_n,
    input wire logic       second_read_enable_n,
    input wire logic       output_enable_n,
    input wire logic [8:0] read_data_out,
    input wire logic       read_data_oe,
    input wire logic       empty_flag_n,
    input wire logic       full_flag_n,
    input wire logic       almost_empty_flag_n,
    input wire logic       almost_full_flag_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_rst_out;
        $rose(rstn) |-> read_data_out == 9'h000 && !empty_flag_n && !almost_empty_flag_n && full_flag_n
            && almost_full_flag_n;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("state after reset");
    property p_oe;
        $past(rstn) |-> read_data_oe == !$past(output_enable_n);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable");
    property p_data_cause;
        $changed(read_data_out) |-> !$past(rstn) || !$past(first_read_enable_n) && !$past(second_read_enable_n);
    endproperty
    a_data_cause: assert property (p_data_cause) else $error("data changed without read");
    // read side lag is a few edges, so five idle read cycles settle it
    property p_full_hold;
        first_read_enable_n [*5] ##0 !full_flag_n |=> !full_flag_n;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full released");
    property p_full_cause;
        $fell(full_flag_n) |-> !$past(primary_write_enable_n);
    endproperty
    a_full_cause: assert property (p_full_cause) else $error("full without write");
    property p_empty_ae;
        !empty_flag_n |-> !almost_empty_flag_n;
    endproperty
    a_empty_ae: assert property (p_empty_ae) else $error("empty not almost empty");
    property p_full_af;
        !full_flag_n |-> !almost_full_flag_n;
    endproperty
    a_full_af: assert property (p_full_af) else $error("full not almost full");
    property p_ae_hold;
        $changed(almost_empty_flag_n) |=> $stable(almost_empty_flag_n);
    endproperty
    a_ae_hold: assert property (p_ae_hold) else $error("flag held too short");
endmodule // fifo_prog_flags_props
bind fifo_prog_flags fifo_prog_flags_props #(.ADDR_W(ADDR_W)) u_props (
    .core_clk(core_clk), .rstn(rstn), .write_data_in(write_data_in),
    .primary_write_enable_n(primary_write_enable_n), .second_write_enable_or_load(second_write_enable_or_load),
    .first_read_enable_n(first_read_enable_n), .second_read_enable_n(second_read_enable_n),
    .output_enable_n(output_enable_n), .read_data_out(read_data_out), .read_data_oe(read_data_oe),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n));

// [fifo_prog_regs.vh]
// constants shared by the programmable-flag fifo files
`ifndef FIFO_PROG_REGS_VH
`define FIFO_PROG_REGS_VH

// word width and default depth (64 words, 6 address bits)
`define FIFO_DATA_W          9
`define FIFO_ADDR_W_DEF      6
`define FIFO_ADDR_W_MAX      13

// offset register sequence positions, rotating in this order
`define SEQ_EMPTY_LOW        2'h0
`define SEQ_EMPTY_HIGH       2'h1
`define SEQ_FULL_LOW         2'h2
`define SEQ_FULL_HIGH        2'h3

// offset register width and reset values (offset of 7 words)
`define OFFSET_W             8
`define OFFSET_LOW_RST       8'h07
`define OFFSET_HIGH_RST      8'h00

// read data value held during reset and pointer crossing stage count
`define READ_DATA_RST        9'h000
`define CROSS_STAGES         2

`endif

// [fifo_side_model.sv]
// producer and consumer model on the far side of the fifo
`timescale 1ns/100ps
module fifo_side_model (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [8:0] read_data_out,
    input  wire logic       read_data_oe,
    output logic      [8:0] write_data_in,
    output logic            primary_write_enable_n,
    output logic            second_write_enable_or_load,
    output logic            first_read_enable_n,
    output logic            second_read_enable_n,
    output wire logic [8:0] q_bus
);
    // floating bus, so a stale word never passes for a driven one
    assign q_bus = read_data_oe ? read_data_out : 9'hZZZ;
    initial begin
        write_data_in = 9'h000;
        {primary_write_enable_n, second_write_enable_or_load} = 2'h3;
        {first_read_enable_n, second_read_enable_n} = 2'h3;
    end
    task automatic idle(input logic lvl);
        @(posedge core_clk);
        #1;
        {primary_write_enable_n, first_read_enable_n, second_read_enable_n} = 3'h7;
        second_write_enable_or_load = lvl;
        write_data_in = ~write_data_in;
    endtask
    task automatic wr(input logic [8:0] d, input logic lvl);
        wait (rstn);
        @(posedge core_clk);
        #1;
        {first_read_enable_n, second_read_enable_n} = 2'h3;
        second_write_enable_or_load = lvl;
        write_data_in = d;
        primary_write_enable_n = 1'b0;
    endtask
    // only one read enable low: must not pop a word
    task automatic rd_half();
        wait (rstn);
        @(posedge core_clk);
        #1;
        {primary_write_enable_n, second_write_enable_or_load} = 2'h3;
        {first_read_enable_n, second_read_enable_n} = 2'h1;
    endtask
    task automatic rd(input logic lvl);
        wait (rstn);
        @(posedge core_clk);
        #1;
        primary_write_enable_n = 1'b1;
        second_write_enable_or_load = lvl;
        {first_read_enable_n, second_read_enable_n} = 2'h0;
    endtask
endmodule // fifo_side_model

// [fifo_storage.v]
// dual-port word array of the fifo
`timescale 1ns/100ps
`include "fifo_prog_regs.vh"

module fifo_storage #(
    parameter ADDR_W = `FIFO_ADDR_W_DEF,
    parameter DATA_W = `FIFO_DATA_W
) (
    input  wire              core_clk,
    input  wire              write_strobe,
    input  wire [ADDR_W-1:0] write_addr,
    input  wire [DATA_W-1:0] write_word,
    input  wire [ADDR_W-1:0] read_addr,
    output wire [DATA_W-1:0] read_word
);

    localparam DEPTH = 1 << ADDR_W;

    // contents carry no reset, as in a plain ram
    reg [DATA_W-1:0] word_mem [0:DEPTH-1];

    always @(posedge core_clk) begin
        if (write_strobe) begin
            word_mem[write_addr] <= write_word;
        end
    end

    // read word is taken by the output register of the top
    assign read_word = word_mem[read_addr];

endmodule // fifo_storage

// [pointer_gray_cross.v]
// passes a binary pointer to the opposite side through gray-coded stages
`timescale 1ns/100ps
`include "fifo_prog_regs.vh"

module pointer_gray_cross #(
    parameter PTR_W = `FIFO_ADDR_W_DEF + 1
) (
    input  wire             core_clk,
    input  wire             rstn,
    input  wire [PTR_W-1:0] bin_in,
    output wire [PTR_W-1:0] bin_out
);

    reg [PTR_W-1:0] gray_reg;
    reg [PTR_W-1:0] stage1_reg;
    reg [PTR_W-1:0] stage2_reg;

    function [PTR_W-1:0] gray_to_bin;
        input [PTR_W-1:0] g;
        integer i;
        begin
            gray_to_bin[PTR_W-1] = g[PTR_W-1];
            for (i = PTR_W - 2; i >= 0; i = i - 1) begin
                gray_to_bin[i] = gray_to_bin[i+1] ^ g[i];
            end
        end
    endfunction

    // only one bit changes per step, so a mid-change sample is one step off
    always @(posedge core_clk) begin
        if (!rstn) begin
            gray_reg   <= {PTR_W{1'b0}};
            stage1_reg <= {PTR_W{1'b0}};
            stage2_reg <= {PTR_W{1'b0}};
        end else begin
            gray_reg   <= bin_in ^ (bin_in >> 1);
            stage1_reg <= gray_reg;
            stage2_reg <= stage1_reg;
        end
    end

    assign bin_out = gray_to_bin(stage2_reg);

endmodule // pointer_gray_cross

// [test_fifo_prog_flags.sv]
// self-checking bench for the programmable-flag fifo
`timescale 1ns/100ps
module test_fifo_prog_flags;
    logic       core_clk;
    logic       rstn;
    logic       output_enable_n;
    wire  [8:0] write_data_in, read_data_out, q_bus;
    wire        primary_write_enable_n, second_write_enable_or_load, first_read_enable_n, second_read_enable_n;
    wire        read_data_oe, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
    int         err_total;
    int         checks_done;
    fifo_prog_flags #(.ADDR_W(6)) u_dut (.core_clk(core_clk), .rstn(rstn), .write_data_in(write_data_in),
        .primary_write_enable_n(primary_write_enable_n), .second_write_enable_or_load(second_write_enable_or_load),
        .first_read_enable_n(first_read_enable_n), .second_read_enable_n(second_read_enable_n),
        .output_enable_n(output_enable_n), .read_data_out(read_data_out), .read_data_oe(read_data_oe),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n));
    fifo_side_model u_side (.core_clk(core_clk), .rstn(rstn), .read_data_out(read_data_out),
        .read_data_oe(read_data_oe), .write_data_in(write_data_in), .primary_write_enable_n(primary_write_enable_n),
        .second_write_enable_or_load(second_write_enable_or_load), .first_read_enable_n(first_read_enable_n),
        .second_read_enable_n(second_read_enable_n), .q_bus(q_bus));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [8:0] w(input int i);
        return 9'(i * 37 + 5);
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // flag order is empty, almost empty, almost full, full
    task automatic flags(input logic [3:0] exp, input string what);
        chk({5'h00, empty_flag_n, almost_empty_flag_n, almost_full_flag_n, full_flag_n}, {5'h00, exp}, what);
    endtask
    // flags cross sides late, six edges covers the lag
    task automatic settle();
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset(input logic mode);
        rstn = 1'b0;
        u_side.idle(mode);
        repeat (4) @(posedge core_clk);
        #1;
        rstn = 1'b1;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_fill();
        int         cnt;
        int         tgt[5] = '{7, 8, 56, 57, 64};
        logic [3:0] exp[5] = '{4'hB, 4'hF, 4'hF, 4'hD, 4'hC};
        cnt = 0;
        foreach (tgt[k]) begin
            while (cnt < tgt[k]) begin
                u_side.wr(w(cnt), 1'b1);
                cnt++;
            end
            u_side.idle(1'b1);
            settle();
            flags(exp[k], "fill level");
        end
        u_side.wr(9'h1AB, 1'b1);
        u_side.idle(1'b1);
        settle();
        flags(4'hC, "write when full");
    endtask
    task automatic t_drain();
        u_side.rd_half();
        u_side.idle(1'b1);
        chk(read_data_out, 9'h000, "half read enable");
        for (int i = 0; i < 64; i++) begin
            u_side.rd(1'b1);
            if (i > 0) chk(read_data_out, w(i - 1), "read order");
        end
        u_side.idle(1'b1);
        repeat (3) u_side.rd(1'b1);
        u_side.idle(1'b1);
        settle();
        chk(read_data_out, w(63), "held when empty");
        flags(4'h3, "drained");
        output_enable_n = 1'b1;
        settle();
        chk(q_bus, 9'hZZZ, "bus released");
        output_enable_n = 1'b0;
        settle();
        chk(q_bus, w(63), "bus driven");
    endtask
    task automatic t_load();
        logic [8:0] ofs[4] = '{9'h003, 9'h000, 9'h002, 9'h000};
        do_reset(1'b0);
        u_side.wr(ofs[0], 1'b0);
        u_side.wr(ofs[1], 1'b0);
        u_side.idle(1'b1);
        u_side.wr(ofs[2], 1'b0);
        u_side.wr(ofs[3], 1'b0);
        u_side.idle(1'b1);
        for (int i = 0; i < 5; i++) begin
            if (i < 4) u_side.rd(1'b0);
            else u_side.idle(1'b1);
            if (i > 0) chk(read_data_out, ofs[i - 1], "offset readback");
        end
        for (int i = 0; i < 4; i++) begin
            u_side.wr(w(i), 1'b1);
            if (i == 2) u_side.idle(1'b1);
            if (i == 2) settle();
            if (i == 2) flags(4'hB, "three words");
        end
        u_side.idle(1'b1);
        settle();
        flags(4'hF, "four words");
        u_side.rd(1'b1);
        u_side.idle(1'b1);
        chk(read_data_out, w(0), "word after load");
    endtask
    initial begin
        {err_total, checks_done} = 0;
        output_enable_n = 1'b0;
        do_reset(1'b1);
        @(posedge core_clk);
        #1;
        chk(read_data_out, 9'h000, "data after reset");
        flags(4'h3, "flags after reset");
        t_fill();
        t_drain();
        t_load();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        wrap_up();
    end
endmodule // test_fifo_prog_flags
